//--- adcs_defines.vh
// Register offsets, field positions, reset values and timing constants of the converter sequencer
`ifndef ADCS_DEFINES_VH
`define ADCS_DEFINES_VH

// Register addresses (3-bit index on the plain register port)
`define ADCS_ADDR_W 3
`define ADCS_OFS_CS1 3'h0
`define ADCS_OFS_CS2 3'h1
`define ADCS_OFS_RH 3'h2
`define ADCS_OFS_RL 3'h3
`define ADCS_OFS_CVH 3'h4
`define ADCS_OFS_CVL 3'h5
`define ADCS_OFS_CFG 3'h6

// Status/control one fields
`define ADCS_CS1_CONV_COMPLETE_FLAG 7
`define ADCS_CS1_COMPLETE_IRQ_ENABLE 6
`define ADCS_CS1_CONT 5
`define ADCS_CH_HI 4
`define ADCS_CH_OFF 5'h1F
`define ADCS_CS1_RESET 8'h1F

// Status/control two fields
`define ADCS_CS2_ACT 7
`define ADCS_CS2_TRG 6
`define ADCS_CS2_CFE 5
`define ADCS_CS2_CGT 4

// Configuration fields
`define ADCS_CFG_LPC 7
`define ADCS_CFG_DIV_HI 6
`define ADCS_CFG_DIV_LO 5
`define ADCS_CFG_LSMP 4
`define ADCS_CFG_MODE_HI 3
`define ADCS_CFG_MODE_LO 2
`define ADCS_CFG_CLK_HI 1
`define ADCS_CFG_CLK_LO 0
`define ADCS_MODE_8 2'h0
`define ADCS_MODE_10 2'h2
`define ADCS_CLK_ASYNC 2'h3
`define ADCS_CLK_HALF 2'h1

// Conversion-clock cycle counts: sample and approximation phases
`define ADCS_SAMP_SHORT 6'h03
`define ADCS_SAMP_LONG 6'h17
`define ADCS_SAR_8 6'h0E
`define ADCS_SAR_10 6'h11
`define ADCS_FIRST_EXTRA 6'h03

// Asynchronous clock start-up time in ns, bus clock period in ns
`define ADCS_ASYNC_START_NS 5000
`define ADCS_CLK_PERIOD_NS 20
`define ADCS_START_W 8

`endif

//--- adcs_sequencer.v
// Conversion sequencer of a successive-approximation converter with register port
//
// How it works
// RL1 - Software start on control-one write, channel not off
// RL2 - Hardware trigger rising edge starts conversion
// RL3 - Continuous mode restarts after every result transfer
// RL4 - Transfer sets complete flag, interrupt if enabled
// RL5 - High read blocks transfer until low read
// RL6 - Blocked transfer restarts conversion, compare-false single stops
// RL7 - Software avoids result reads during single conversion
// RL8 - Control-one write aborts, then restarts unless off
// RL9 - Other config writes abort without restart
// RL10 - Abort keeps results; reset clears them
// RL11 - Idle until started; async clock only active
// RL12 - Sample short or long, then approximate, transfer
// RL13 - Short sample first: 20/23 clocks plus 5
// RL14 - Long sample first: 40/43 clocks plus 5
// RL15 - Async clock adds 5 us start-up
// RL16 - Later continuous: 17/20 or 37/40 clocks
// RL17 - Exact continuous timing needs adequate bus rate
// RL18 - Compare adds two's complement, greater-or-less test
// RL19 - Compare true stores difference; false transfers nothing
// RL20 - Wait: conversion continues, completion wakes system
// RL21 - Wait keeps bus, half-bus, async clocks usable
// RL22 - Stop without async clock aborts, idles
// RL23 - Trigger ignored while busy or continuous
// RL24 - Ten bits over both bytes, eight in low
// RL25 - Disabled in reset or channel all ones
// RL26 - Low read or control write releases guard
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "adcs_defines.vh"

module adcs_sequencer (
  // Clock, reset, enable
  input wire clock,
  input wire arst_n,
  input wire clk_en,
  // Register port
  input wire [`ADCS_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // System state and trigger
  input wire hw_trigger_in,
  input wire stop_mode,
  input wire alternate_clock_tick,
  // Analog core
  input wire [10:0] sar_raw,
  output wire sample_active,
  output wire async_conv_clock_enable,
  output wire [4:0] channel_select,
  output wire low_power_config,
  // Completion
  output wire conv_complete_irq
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_SAMPLE = 4'b0100;
  localparam ST_CONVERT = 4'b1000;

  // Start-up allowance of the async source, rounded up to whole bus cycles
  localparam integer START_RAW =
    (`ADCS_ASYNC_START_NS + `ADCS_CLK_PERIOD_NS - 1) / `ADCS_CLK_PERIOD_NS;
  // Cut on purpose: the allowance fits the start counter width
  localparam [`ADCS_START_W-1:0] START_CYCLES = START_RAW[`ADCS_START_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Timing overview
  // A start request spends one bus cycle in the start state, or the whole start-up allowance with the async source, then counts
  // conversion-clock ticks only. Sampling lasts a short or a long window,
  // then the approximation phase runs for the width of the result.
  // The first conversion of a series carries a few extra ticks, which
  // stand for the converter settling after it leaves idle.
  // Later conversions of a continuous series go straight back to sampling,
  // so their length is sampling plus approximation only.
  // With the async source selected, the first conversion also waits out a
  // start-up allowance counted in bus cycles before sampling begins.
  // Limitation: the async source is modelled on the bus clock, so its
  // conversions are as fast as a bus-clock conversion after start-up.
  // Aborts return to idle at once, a restarting control-one write to start; the result pair is never touched by an
  // abort, only by a transfer or by reset.
  // Hazard: a transfer and a high-byte read in one cycle see the guard still
  // open, so the transfer lands; the guard closes on the next cycle.
  // The read guard only has meaning in 10-bit mode, where the result spans
  // both bytes; in 8-bit mode the low byte alone holds the result.
  // Clock enable low freezes every counter, flag and register except the reset synchroniser,
  // read data included, so the block simply skips those bus cycles.
  // The complete flag is set by a transfer and cleared by a control-one
  // write or read; a transfer in the cycle of a read wins.
  // The trigger history register starts low, matching the idle level of the
  // trigger, so no false edge follows reset.
  // Trade-off: sample and approximation lengths share one six-bit counter, reloaded at each
  // phase change, instead of a counter per phase.

  //////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  reg rst_meta;
  reg rst_sync_n;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers and state
  reg [7:0] cs1;
  reg [7:0] cs2;
  reg [7:0] cfg;
  reg [7:0] cvh;
  reg [7:0] cvl;
  reg [7:0] result_high;
  reg [7:0] result_low;
  reg [3:0] state;
  reg [5:0] phase_cnt;
  reg [`ADCS_START_W-1:0] start_cnt;
  reg [3:0] div_cnt;
  reg first_conv;
  reg read_guard;
  reg trig_prev;
  reg half_tog;

  wire cont = cs1[`ADCS_CS1_CONT];
  wire [1:0] mode = cfg[`ADCS_CFG_MODE_HI:`ADCS_CFG_MODE_LO];
  wire [1:0] clk_sel = cfg[`ADCS_CFG_CLK_HI:`ADCS_CFG_CLK_LO];
  wire [1:0] div_sel = cfg[`ADCS_CFG_DIV_HI:`ADCS_CFG_DIV_LO];
  wire long_sample = cfg[`ADCS_CFG_LSMP];
  wire hw_trig_sel = cs2[`ADCS_CS2_TRG];
  wire cmp_en = cs2[`ADCS_CS2_CFE];
  wire cmp_gt = cs2[`ADCS_CS2_CGT];
  wire is_async = (clk_sel == `ADCS_CLK_ASYNC);
  wire chan_off = (cs1[`ADCS_CH_HI:0] == `ADCS_CH_OFF);
  wire busy = (state != ST_IDLE);

  assign channel_select = cs1[`ADCS_CH_HI:0];
  assign low_power_config = cfg[`ADCS_CFG_LPC];
  assign sample_active = (state == ST_SAMPLE);
  assign async_conv_clock_enable = busy && is_async; // [RL11]
  assign conv_complete_irq = cs1[`ADCS_CS1_CONV_COMPLETE_FLAG] && cs1[`ADCS_CS1_COMPLETE_IRQ_ENABLE]; // [RL4] [RL20]

  // Register strobes
  wire wr_cs1 = reg_write && (reg_addr == `ADCS_OFS_CS1);
  wire wr_cfgs = reg_write && ((reg_addr == `ADCS_OFS_CS2) || (reg_addr == `ADCS_OFS_CFG) ||
                 (reg_addr == `ADCS_OFS_CVH) || (reg_addr == `ADCS_OFS_CVL));
  wire rd_high = reg_read && (reg_addr == `ADCS_OFS_RH);
  wire rd_low = reg_read && (reg_addr == `ADCS_OFS_RL);
  wire wr_chan_off = (reg_wdata[`ADCS_CH_HI:0] == `ADCS_CH_OFF);

  //////////////////////////////////////////////////////////////////////////////
  // Conversion clock tick: source select then divide by 1, 2, 4 or 8
  // The async source is modelled on the bus clock; its real oscillator sits outside.
  reg src_tick;
  always @* begin
    case (clk_sel)
      2'h0: src_tick = 1'b1;
      `ADCS_CLK_HALF: src_tick = half_tog;
      2'h2: src_tick = alternate_clock_tick;
      default: src_tick = 1'b1; // [RL21]
    endcase
  end
  wire [3:0] div_mask = (4'h1 << div_sel) - 4'h1;
  wire conv_tick = src_tick && ((div_cnt & div_mask) == 4'h0);

  //////////////////////////////////////////////////////////////////////////////
  // Result shaping and compare
  // Rounding: add half an LSB of the target width before truncation.
  wire [11:0] rnd10 = {1'b0, sar_raw} + 12'h001;
  wire [9:0] res10 = rnd10[11] ? 10'h3FF : rnd10[10:1];
  wire [9:0] rnd8 = {1'b0, sar_raw[10:2]} + 10'h001;
  wire [7:0] res8 = rnd8[9] ? 8'hFF : rnd8[8:1]; // [RL24]
  wire is10 = (mode == `ADCS_MODE_10);
  wire [9:0] res_val = is10 ? res10 : {2'h0, res8};
  wire [9:0] cmp_val = is10 ? {cvh[1:0], cvl} : {2'h0, cvl};
  wire [10:0] diff = {1'b0, res_val} + {1'b0, ~cmp_val} + 11'h001; // [RL18]
  wire ge = diff[10];
  wire cmp_true = cmp_gt ? ge : ~ge; // [RL18]
  wire cmp_pass = !cmp_en || cmp_true;
  wire [9:0] store_val = cmp_en ? diff[9:0] : res_val; // [RL19]
  wire blocked = read_guard && is10; // [RL5]

  //////////////////////////////////////////////////////////////////////////////
  // Phase lengths in conversion-clock cycles
  wire [5:0] samp_len = long_sample ? `ADCS_SAMP_LONG : `ADCS_SAMP_SHORT; // [RL12]
  wire [5:0] sar_len = (is10 ? `ADCS_SAR_10 : `ADCS_SAR_8) +
                       (first_conv ? `ADCS_FIRST_EXTRA : 6'h00); // [RL13] [RL14] [RL16]

  wire trig_edge = hw_trigger_in && !trig_prev;
  wire done = (state == ST_CONVERT) && conv_tick && (phase_cnt == 6'h00);

  //////////////////////////////////////////////////////////////////////////////
  // Source divider, trigger history and half-rate toggle
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt <= 4'h0;
      trig_prev <= 1'b0;
      half_tog <= 1'b0;
    end else if (clk_en) begin
      half_tog <= ~half_tog;
      trig_prev <= hw_trigger_in; // [RL2]
      // Divider only advances on source ticks
      if (src_tick)
        div_cnt <= div_cnt + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read guard: a high read in 10-bit mode locks transfers until the low read.
  // A control-one write releases it, so software cannot leave it stuck.
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n)
      read_guard <= 1'b0;
    else if (clk_en) begin
      if (wr_cs1)
        read_guard <= 1'b0; // [RL26]
      else if (rd_high && is10)
        read_guard <= 1'b1; // [RL5]
      else if (rd_low)
        read_guard <= 1'b0; // [RL26]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode registers; read-only and reserved bits are held at zero
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cs2 <= 8'h00;
      cfg <= 8'h00;
      cvh <= 8'h00;
      cvl <= 8'h00;
    end else if (clk_en && reg_write) begin
      case (reg_addr)
        `ADCS_OFS_CS2: cs2 <= {1'b0, reg_wdata[6:4], 4'h0};
        `ADCS_OFS_CFG: cfg <= reg_wdata;
        `ADCS_OFS_CVH: cvh <= {6'h00, reg_wdata[1:0]};
        `ADCS_OFS_CVL: cvl <= reg_wdata;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and register writes
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cs1 <= `ADCS_CS1_RESET; // [RL25]
      result_high <= 8'h00; // [RL10]
      result_low <= 8'h00;
      state <= ST_IDLE;
      phase_cnt <= 6'h00;
      start_cnt <= {`ADCS_START_W{1'b0}};
      first_conv <= 1'b1;
    end else if (clk_en) begin
      // Conversion sequence
      if (wr_cs1) begin
        // Write clears the flag; abort and maybe restart
        cs1 <= {1'b0, reg_wdata[6:0]};
        first_conv <= 1'b1;
        if (!wr_chan_off && !hw_trig_sel)
          state <= ST_START; // [RL1] [RL8]
        else
          state <= ST_IDLE; // [RL8] [RL25]
      end else if (wr_cfgs || (stop_mode && !is_async)) begin
        state <= ST_IDLE; // [RL9] [RL22] [RL10]
        first_conv <= 1'b1;
      end else begin
        // Flag cleared by reading control one unless a conversion ends this cycle
        if (reg_read && reg_addr == `ADCS_OFS_CS1 && !done)
          cs1[`ADCS_CS1_CONV_COMPLETE_FLAG] <= 1'b0;
        case (state)
          ST_IDLE: begin
            if (hw_trig_sel && trig_edge && !chan_off) begin
              state <= ST_START; // [RL2] [RL23]
              first_conv <= 1'b1;
            end
          end
          ST_START: begin
            // Async source start-up delay before sampling
            phase_cnt <= samp_len - 6'h01;
            if (is_async && start_cnt != START_CYCLES - 8'h01 && first_conv) begin
              start_cnt <= start_cnt + 8'h01; // [RL15]
            end else begin
              start_cnt <= {`ADCS_START_W{1'b0}};
              state <= ST_SAMPLE;
            end
          end
          ST_SAMPLE: begin
            if (conv_tick) begin
              if (phase_cnt == 6'h00) begin
                phase_cnt <= sar_len - 6'h01;
                state <= ST_CONVERT; // [RL12]
              end else
                phase_cnt <= phase_cnt - 6'h01;
            end
          end
          ST_CONVERT: begin
            if (conv_tick) begin
              if (phase_cnt == 6'h00) begin
                first_conv <= 1'b0;
                if (blocked) begin
                  // Discard; keep converting unless a single compare failed
                  if (!cont && !cmp_pass)
                    state <= ST_IDLE; // [RL6]
                  else begin
                    state <= ST_SAMPLE; // [RL6]
                    phase_cnt <= samp_len - 6'h01;
                  end
                end else begin
                  if (cmp_pass) begin
                    result_high <= {6'h00, store_val[9:8]}; // [RL24]
                    result_low <= store_val[7:0];
                    cs1[`ADCS_CS1_CONV_COMPLETE_FLAG] <= 1'b1; // [RL4] [RL19]
                  end
                  if (cont) begin
                    state <= ST_SAMPLE; // [RL3] [RL16]
                    phase_cnt <= samp_len - 6'h01;
                  end else
                    state <= ST_IDLE; // [RL11]
                end
              end else
                phase_cnt <= phase_cnt - 6'h01;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read select; unmapped indices give zero
  reg [7:0] rd_mux;
  always @* begin
    case (reg_addr)
      `ADCS_OFS_CS1: rd_mux = cs1;
      `ADCS_OFS_CS2: rd_mux = {busy, cs2[6:0]};
      `ADCS_OFS_RH: rd_mux = result_high;
      `ADCS_OFS_RL: rd_mux = result_low;
      `ADCS_OFS_CVH: rd_mux = cvh;
      `ADCS_OFS_CVL: rd_mux = cvl;
      `ADCS_OFS_CFG: rd_mux = cfg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data, one cycle after the strobe, zero otherwise
  // Zero between reads keeps stale result bytes off the bus.
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n)
      reg_rdata <= 8'h00;
    else if (clk_en) begin
      if (reg_read)
        reg_rdata <= rd_mux;
      else
        reg_rdata <= 8'h00;
    end
  end

endmodule // adcs_sequencer

//--- adcs_sequencer_checker.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
`include "adcs_defines.vh"
module adcs_sequencer_checker (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  input wire clk_en,
  // Register port
  input wire [`ADCS_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  // System state and core
  input wire stop_mode,
  input wire sample_active,
  input wire async_conv_clock_enable,
  input wire [4:0] channel_select,
  input wire conv_complete_irq
);
  reg [1:0] clk_sel;
  reg trg;
  // Shadows of clock and trigger fields, the outputs depend on them
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clk_sel <= 2'h0;
      trg <= 1'b0;
    end else if (reg_write && clk_en) begin
      if (reg_addr == `ADCS_OFS_CFG) clk_sel <= reg_wdata[1:0];
      if (reg_addr == `ADCS_OFS_CS2) trg <= reg_wdata[6];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_cs1;
    reg_write && clk_en && reg_addr == `ADCS_OFS_CS1;
  endsequence
  sequence s_mode_wr;
    reg_write && clk_en && reg_addr != `ADCS_OFS_CS1 && reg_addr != `ADCS_OFS_RH && reg_addr != `ADCS_OFS_RL;
  endsequence
  // Port relations
  AST_CHAN_OFF_IDLE: assert property (channel_select == 5'h1F |-> !sample_active)
    else $error("sampling with channel off");
  AST_MODE_WR_ABORT: assert property (s_mode_wr ##0 reg_addr != 3'h7 |=> !sample_active)
    else $error("mode write did not abort");
  AST_STOP_ABORT: assert property ($rose(stop_mode) && clk_en && clk_sel != 2'h3 |=> !sample_active [*2])
    else $error("stop entry did not abort");
  AST_ASYNC_ONLY_SEL: assert property (clk_sel != 2'h3 |-> !async_conv_clock_enable)
    else $error("async clock enabled while not selected");
  AST_ASYNC_ACTIVE: assert property (sample_active && clk_sel == 2'h3 |-> async_conv_clock_enable)
    else $error("async clock off while active");
  AST_IRQ_EN_OFF: assert property (s_cs1 ##0 !reg_wdata[6] |=> !conv_complete_irq)
    else $error("interrupt with enable clear");
  AST_CHAN_FOLLOW: assert property (s_cs1 |=> channel_select == $past(reg_wdata[4:0]))
    else $error("channel field not updated");
  AST_CS1_START: assert property (s_cs1 ##0 (reg_wdata[4:0] != 5'h1F && !trg && clk_sel != 2'h3 && !stop_mode)
    |-> ##[1:3] sample_active)
    else $error("software start missing");
endmodule // adcs_sequencer_checker

bind adcs_sequencer adcs_sequencer_checker i_adcs_sequencer_checker (.*);

//--- adcs_sequencer_test.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
`include "adcs_defines.vh"
module adcs_sequencer_test;
  reg clock, arst_n = 0, clk_en = 1, reg_write = 0, reg_read = 0;
  reg [2:0] reg_addr = 0;
  reg [7:0] reg_wdata = 0;
  reg hw_trigger_in = 0, stop_mode = 0, alternate_clock_tick = 0, rd_seen = 0;
  reg [10:0] sar_raw = 0;
  reg [9:0] r, cv;
  wire [7:0] reg_rdata;
  wire sample_active, async_conv_clock_enable, low_power_config, conv_complete_irq;
  wire [4:0] channel_select;
  integer fail_count = 0, num_checks = 0, cyc = 0, seed = 32'h900b, n, i;
  logic [7:0] exp_q[$];
  adcs_sequencer i_adcs_sequencer (.*);
  ////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bus cycles; reads leave their expected byte in the queue
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input [2:0] a, input [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  // Bounded wait for completion, counted from the last request
  task wait_irq(input integer lim);
    n = 0;
    do begin
      @(negedge clock);
      n = n + 1;
    end while (conv_complete_irq !== 1'b1 && n < 400);
    chk(n <= lim + 1, 1);
  endtask
  task quiet(input integer k);
    repeat (k) begin
      @(negedge clock);
      chk(conv_complete_irq, 0);
    end
  endtask
  // Read data stand one cycle after the strobe only
  always @(posedge clock) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_read;
    alternate_clock_tick <= $random(seed);
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // Single conversions over width and sample length
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed) | 10'h040;
      sar_raw <= {r, 1'b0};
      wr(6, {3'h0, i[1], i[0], 3'h0});
      wr(0, 8'h41);
      wait_irq(25 + 3 * i[0] + 20 * i[1]);
      rd(0, 8'hC1);
      if (i[0]) rd(2, {6'h0, r[9:8]});
      if (i[0]) rd(3, r[7:0]);
    end
    // Async clock start-up allowance
    wr(6, 8'h0B);
    wr(0, 8'h41);
    wait_irq(278);
    // Half bus rate conversion clock, 10-bit short sample
    wr(6, 8'h09);
    wr(0, 8'h41);
    wait_irq(51);
    // Continuous series with a half-read result blocking transfers
    wr(6, 8'h08);
    wr(0, 8'h61);
    wait_irq(28);
    rd(0, 8'hE1);
    rd(2, {6'h0, r[9:8]});
    sar_raw <= {~r, 1'b0};
    quiet(60);
    rd(3, r[7:0]);
    wait_irq(25);
    rd(2, {6'h0, ~r[9:8]});
    rd(3, ~r[7:0]);
    wr(0, 8'h1F);
    // Abort by mode write, then by stop entry
    sar_raw <= {r, 1'b0};
    for (i = 0; i < 2; i = i + 1) begin
      wr(0, 8'h41);
      repeat (5) @(posedge clock);
      if (i) stop_mode <= 1'b1;
      else wr(5, 8'h00);
      quiet(40);
      @(posedge clock);
      stop_mode <= 1'b0;
      quiet(20);
      rd(3, ~r[7:0]);
    end
    // Compare: greater-or-equal true, then less-than false
    cv = r - 10'h005;
    for (i = 0; i < 2; i = i + 1) begin
      wr(4, {6'h0, cv[9:8]});
      wr(5, cv[7:0]);
      wr(1, i ? 8'h20 : 8'h30);
      wr(0, 8'h41);
      if (i) quiet(60);
      else wait_irq(28);
    end
    rd(2, 8'h00);
    rd(3, 8'h05);
    // Hardware trigger waits for its rising edge
    wr(1, 8'h40);
    wr(0, 8'h41);
    quiet(30);
    @(posedge clock);
    hw_trigger_in <= 1'b1;
    wait_irq(28);
    @(posedge clock);
    hw_trigger_in <= 1'b0;
    repeat (3) @(posedge clock);
    finish_test;
  end
endmodule // adcs_sequencer_test
